//--- include/wdtom_pkg.sv
package wdtom_pkg;

    // system clock and the two watchdog clock sources
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned LS_OSC_HZ = 240_000;
    localparam int unsigned X1_OSC_HZ = 20_000_000;
    localparam int unsigned LS_DIV = CLK_HZ / LS_OSC_HZ;
    localparam int unsigned X1_DIV = CLK_HZ / X1_OSC_HZ;
    localparam int unsigned DIV_W = 8;

    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_MODE = 16'hFF98;
    localparam logic [15:0] IDX_CLEAR_KEY = 16'hFF99;
    localparam logic [15:0] IDX_SYS_CTRL = 16'hFF9A;
    localparam logic [15:0] IDX_STATUS = 16'hFF9B;

    localparam logic [1:0] SEL_MODE = 2'h0;
    localparam logic [1:0] SEL_CLEAR_KEY = 2'h1;
    localparam logic [1:0] SEL_SYS_CTRL = 2'h2;
    localparam logic [1:0] SEL_STATUS = 2'h3;

    // mode register layout and reset value
    localparam logic [2:0] MODE_FIXED_TOP = 3'h3;
    localparam logic [1:0] CLK_SEL_RESET = 2'h0;
    localparam logic [2:0] PERIOD_RESET = 3'h7;
    localparam logic [1:0] CLK_SEL_LS = 2'h0;
    localparam logic [1:0] CLK_SEL_X1 = 2'h1;
    localparam int unsigned CLK_SEL_LO = 3;
    localparam int unsigned PERIOD_LO = 0;

    // clear register
    localparam logic [7:0] CLEAR_KEY = 8'hAC;
    localparam logic [7:0] CLEAR_READ = 8'h9A;
    localparam int unsigned CLEAR_BITOP_BIT = 8;

    // system control bits
    localparam int unsigned SYS_HALT_BIT = 0;
    localparam int unsigned SYS_STOP_BIT = 1;
    localparam int unsigned SYS_CPU_X1_BIT = 2;
    localparam int unsigned SYS_STAB_SEL_LO = 4;
    localparam logic [2:0] STAB_SEL_RESET = 3'h0;

    // overflow and stabilisation exponents
    localparam int unsigned LS_SHIFT_BASE = 11;
    localparam int unsigned X1_SHIFT_BASE = 13;
    localparam int unsigned OST_SHIFT_BASE = 11;
    localparam int unsigned CNT_W = 21;
    localparam int unsigned STAB_W = 19;

    localparam logic [1:0] AXI_OKAY = 2'h0;
    localparam logic [1:0] AXI_SLVERR = 2'h2;

    typedef enum logic [1:0] {PH_RUN, PH_STOP, PH_STAB} wdtom_phase_t;

    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } wdtom_div_t;

    typedef struct packed {
        logic aw_full;
        logic [31:0] awaddr;
        logic w_full;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } wdtom_axi_t;

    typedef struct packed {
        logic option_taken;
        logic nonstop;
        logic mode_written;
        logic [1:0] clk_sel;
        logic [2:0] period;
        logic [CNT_W-1:0] count;
        logic rst_req;
        logic halt;
        logic stop;
        logic cpu_x1;
        logic [2:0] osc_stabilize_time_select;
        wdtom_phase_t phase;
        logic [STAB_W-1:0] stab_cnt;
        logic wake_cpu_x1;
        logic wake_wd_x1;
    } wdtom_core_t;

    typedef struct packed {
        wdtom_axi_t axi;
        wdtom_core_t core;
    } wdtom_state_t;

endpackage : wdtom_pkg

//--- core/wdtom_tick_div.sv
`timescale 1ns/1ps
module wdtom_tick_div #(
    parameter int unsigned DIV = 2
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    output logic tick_out
);
    localparam logic [wdtom_pkg::DIV_W-1:0] LAST = wdtom_pkg::DIV_W'(DIV - 1);

    wdtom_pkg::wdtom_div_t s_q;
    wdtom_pkg::wdtom_div_t s_d;

    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt == LAST) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick_out = s_q.tick;

endmodule : wdtom_tick_div

//--- core/wdtom_top.sv
`timescale 1ns/1ps
module wdtom_top (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic option_nonstop_in,
    input wire logic [31:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [31:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic wdt_reset_req_out
);
    localparam int unsigned CW = wdtom_pkg::CNT_W;
    localparam int unsigned SW = wdtom_pkg::STAB_W;

    wdtom_pkg::wdtom_state_t s_q;
    wdtom_pkg::wdtom_state_t s_d;

    logic ls_tick;
    logic x1_tick;

    // address decode: {hit, select}
    function automatic logic [2:0] wdtom_decode(input logic [31:0] addr);
        logic [2:0] r;
        r = 3'h0;
        if (addr[31:18] == 14'h0000) begin
            if (addr[17:2] == wdtom_pkg::IDX_MODE) begin
                r = {1'b1, wdtom_pkg::SEL_MODE};
            end else if (addr[17:2] == wdtom_pkg::IDX_CLEAR_KEY) begin
                r = {1'b1, wdtom_pkg::SEL_CLEAR_KEY};
            end else if (addr[17:2] == wdtom_pkg::IDX_SYS_CTRL) begin
                r = {1'b1, wdtom_pkg::SEL_SYS_CTRL};
            end else if (addr[17:2] == wdtom_pkg::IDX_STATUS) begin
                r = {1'b1, wdtom_pkg::SEL_STATUS};
            end
        end
        return r;
    endfunction : wdtom_decode

    // overflow limit as a power of two of the selected clock
    function automatic logic [CW-1:0] wdtom_limit(input logic x1, input logic [2:0] per);
        logic [4:0] sh;
        sh = 5'(per) + (x1 ? 5'(wdtom_pkg::X1_SHIFT_BASE) : 5'(wdtom_pkg::LS_SHIFT_BASE));
        return CW'(1) << sh;
    endfunction : wdtom_limit

    wdtom_tick_div #(
        .DIV(wdtom_pkg::LS_DIV)
    ) u_ls_div (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .tick_out(ls_tick)
    );

    wdtom_tick_div #(
        .DIV(wdtom_pkg::X1_DIV)
    ) u_x1_div (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .tick_out(x1_tick)
    );

    // decoded views of the current state
    logic wd_stopped;
    logic eff_x1;
    logic wd_tick;
    logic run;
    logic [CW-1:0] limit;
    logic [SW-1:0] stab_limit;
    logic wr_fire;
    logic [2:0] wr_dec;
    logic wr_hit;
    logic wr_lane;
    logic wr_mode;
    logic wr_clear;
    logic key_ok;
    logic bitop;
    logic [2:0] rd_dec;
    logic ovf;

    assign wd_stopped = !s_q.core.nonstop && s_q.core.clk_sel[1];
    assign eff_x1 = !s_q.core.nonstop && (s_q.core.clk_sel == wdtom_pkg::CLK_SEL_X1);
    assign wd_tick = eff_x1 ? x1_tick : ls_tick;
    assign run = s_q.core.option_taken && !s_q.core.rst_req && (s_q.core.nonstop
        || (!wd_stopped && !s_q.core.halt && !s_q.core.stop
        && s_q.core.phase == wdtom_pkg::PH_RUN));
    assign limit = wdtom_limit(eff_x1, s_q.core.period);
    assign stab_limit = SW'(1)
        << (5'(s_q.core.osc_stabilize_time_select) + 5'(wdtom_pkg::OST_SHIFT_BASE));
    assign wr_fire = s_q.axi.aw_full && s_q.axi.w_full && !s_q.axi.bvalid;
    assign wr_dec = wdtom_decode(s_q.axi.awaddr);
    assign wr_hit = wr_fire && wr_dec[2];
    assign wr_lane = s_q.axi.wstrb[0];
    assign wr_mode = wr_hit && wr_lane && wr_dec[1:0] == wdtom_pkg::SEL_MODE;
    assign wr_clear = wr_hit && wr_lane && wr_dec[1:0] == wdtom_pkg::SEL_CLEAR_KEY;
    assign bitop = s_q.axi.wdata[wdtom_pkg::CLEAR_BITOP_BIT];
    assign key_ok = !bitop && s_q.axi.wdata[7:0] == wdtom_pkg::CLEAR_KEY;
    assign rd_dec = wdtom_decode(s_axi_araddr_in);
    assign ovf = run && wd_tick && s_q.core.count == limit - CW'(1);

    always_comb begin
        logic [31:0] rd;
        rd = 32'h0000_0000;
        s_d = s_q;

        // option byte capture one edge after reset release
        if (!s_q.core.option_taken) begin
            s_d.core.option_taken = 1'b1;
            s_d.core.nonstop = option_nonstop_in;
        end

        // counting
        if (ovf) begin
            s_d.core.rst_req = 1'b1;
        end else if (run && wd_tick) begin
            s_d.core.count = s_q.core.count + CW'(1);
        end

        // low-power sequencing, stoppable variant only
        case (s_q.core.phase)
            wdtom_pkg::PH_RUN: begin
                if (!s_q.core.nonstop && s_q.core.stop) begin
                    s_d.core.phase = wdtom_pkg::PH_STOP;
                    s_d.core.wake_cpu_x1 = s_q.core.cpu_x1;
                    s_d.core.wake_wd_x1 = eff_x1;
                end
            end
            wdtom_pkg::PH_STOP: begin
                if (!s_q.core.stop) begin
                    s_d.core.stab_cnt = '0;
                    if (s_q.core.wake_wd_x1) begin
                        s_d.core.phase = wdtom_pkg::PH_STAB;
                    end else begin
                        s_d.core.phase = wdtom_pkg::PH_RUN;
                    end
                end
            end
            wdtom_pkg::PH_STAB: begin
                if (s_q.core.stop) begin
                    s_d.core.phase = wdtom_pkg::PH_STOP;
                end else if (!s_q.core.wake_cpu_x1 && s_q.core.cpu_x1) begin
                    s_d.core.phase = wdtom_pkg::PH_RUN;
                end else if (x1_tick) begin
                    if (s_q.core.stab_cnt == stab_limit - SW'(1)) begin
                        s_d.core.phase = wdtom_pkg::PH_RUN;
                    end else begin
                        s_d.core.stab_cnt = s_q.core.stab_cnt + SW'(1);
                    end
                end
            end
            default: begin
                s_d.core.phase = wdtom_pkg::PH_RUN;
            end
        endcase

        // register writes take priority over the tick on the counter
        if (wr_mode) begin
            if (!s_q.core.mode_written) begin
                s_d.core.mode_written = 1'b1;
                s_d.core.period = s_q.axi.wdata[wdtom_pkg::PERIOD_LO +: 3];
                s_d.core.clk_sel = s_q.core.nonstop ? wdtom_pkg::CLK_SEL_LS
                    : s_q.axi.wdata[wdtom_pkg::CLK_SEL_LO +: 2];
                s_d.core.count = '0;
            end else if (!wd_stopped) begin
                s_d.core.rst_req = 1'b1;
            end
        end
        if (wr_clear) begin
            if (key_ok) begin
                s_d.core.count = '0;
            end else if (!wd_stopped) begin
                s_d.core.rst_req = 1'b1;
            end
        end
        if (wr_hit && wr_lane && wr_dec[1:0] == wdtom_pkg::SEL_SYS_CTRL) begin
            s_d.core.halt = s_q.axi.wdata[wdtom_pkg::SYS_HALT_BIT];
            s_d.core.stop = s_q.axi.wdata[wdtom_pkg::SYS_STOP_BIT];
            s_d.core.cpu_x1 = s_q.axi.wdata[wdtom_pkg::SYS_CPU_X1_BIT];
            s_d.core.osc_stabilize_time_select = s_q.axi.wdata[wdtom_pkg::SYS_STAB_SEL_LO +: 3];
        end

        // write channel
        if (s_axi_awvalid_in && s_q.axi.awready) begin
            s_d.axi.aw_full = 1'b1;
            s_d.axi.awaddr = s_axi_awaddr_in;
        end
        if (s_axi_wvalid_in && s_q.axi.wready) begin
            s_d.axi.w_full = 1'b1;
            s_d.axi.wdata = s_axi_wdata_in;
            s_d.axi.wstrb = s_axi_wstrb_in;
        end
        if (wr_fire) begin
            s_d.axi.aw_full = 1'b0;
            s_d.axi.w_full = 1'b0;
            s_d.axi.bvalid = 1'b1;
            s_d.axi.bresp = wr_dec[2] ? wdtom_pkg::AXI_OKAY : wdtom_pkg::AXI_SLVERR;
        end else if (s_q.axi.bvalid && s_axi_bready_in) begin
            s_d.axi.bvalid = 1'b0;
        end

        // read channel
        case (rd_dec[1:0])
            wdtom_pkg::SEL_MODE: begin
                rd[7:0] = {wdtom_pkg::MODE_FIXED_TOP, s_q.core.clk_sel, s_q.core.period};
            end
            wdtom_pkg::SEL_CLEAR_KEY: begin
                rd[7:0] = wdtom_pkg::CLEAR_READ;
            end
            wdtom_pkg::SEL_SYS_CTRL: begin
                rd[wdtom_pkg::SYS_HALT_BIT] = s_q.core.halt;
                rd[wdtom_pkg::SYS_STOP_BIT] = s_q.core.stop;
                rd[wdtom_pkg::SYS_CPU_X1_BIT] = s_q.core.cpu_x1;
                rd[wdtom_pkg::SYS_STAB_SEL_LO +: 3] = s_q.core.osc_stabilize_time_select;
            end
            wdtom_pkg::SEL_STATUS: begin
                rd[CW-1:0] = s_q.core.count;
                rd[CW] = s_q.core.rst_req;
                rd[CW+1] = s_q.core.nonstop;
                rd[CW+2] = s_q.core.phase != wdtom_pkg::PH_RUN;
                rd[CW+3] = s_q.core.mode_written;
            end
            default: begin
                rd = 32'h0000_0000;
            end
        endcase
        if (s_axi_arvalid_in && s_q.axi.arready) begin
            s_d.axi.rvalid = 1'b1;
            s_d.axi.rdata = rd_dec[2] ? rd : 32'h0000_0000;
            s_d.axi.rresp = rd_dec[2] ? wdtom_pkg::AXI_OKAY : wdtom_pkg::AXI_SLVERR;
        end else if (s_q.axi.rvalid && s_axi_rready_in) begin
            s_d.axi.rvalid = 1'b0;
        end

        // one write and one read at a time
        s_d.axi.awready = !s_d.axi.aw_full && !s_d.axi.bvalid;
        s_d.axi.wready = !s_d.axi.w_full && !s_d.axi.bvalid;
        s_d.axi.arready = !s_d.axi.rvalid;
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
            s_q.axi.awready <= 1'b1;
            s_q.axi.wready <= 1'b1;
            s_q.axi.arready <= 1'b1;
            s_q.core.clk_sel <= wdtom_pkg::CLK_SEL_RESET;
            s_q.core.period <= wdtom_pkg::PERIOD_RESET;
            s_q.core.osc_stabilize_time_select <= wdtom_pkg::STAB_SEL_RESET;
            s_q.core.phase <= wdtom_pkg::PH_RUN;
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_awready_out = s_q.axi.awready;
    assign s_axi_wready_out = s_q.axi.wready;
    assign s_axi_bvalid_out = s_q.axi.bvalid;
    assign s_axi_bresp_out = s_q.axi.bresp;
    assign s_axi_arready_out = s_q.axi.arready;
    assign s_axi_rvalid_out = s_q.axi.rvalid;
    assign s_axi_rdata_out = s_q.axi.rdata;
    assign s_axi_rresp_out = s_q.axi.rresp;
    assign wdt_reset_req_out = s_q.core.rst_req;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_req_sticky: assert property (s_q.core.rst_req |=> s_q.core.rst_req [*4])
        else $error("reset request dropped");
    a_overflow_req: assert property (ovf |=> wdt_reset_req_out)
        else $error("overflow without reset request");
    a_mode_clears: assert property (wr_mode && !s_q.core.mode_written
        |=> s_q.core.count == '0)
        else $error("mode write did not clear counter");
    a_key_clears: assert property (wr_clear && key_ok && !ovf
        |=> s_q.core.count == '0)
        else $error("key write did not clear counter");
    a_bad_key: assert property (wr_clear && !key_ok && !wd_stopped
        |=> wdt_reset_req_out)
        else $error("bad key did not raise reset");
    a_second_mode: assert property (wr_mode && s_q.core.mode_written && !wd_stopped
        |=> wdt_reset_req_out)
        else $error("second mode write did not raise reset");
    a_stopped_quiet: assert property (wd_stopped && !s_q.core.rst_req
        |=> !s_q.core.rst_req)
        else $error("stopped watchdog raised reset");
    a_nonstop_clock: assert property (s_q.core.nonstop
        |-> s_q.core.clk_sel == wdtom_pkg::CLK_SEL_LS)
        else $error("non-stoppable variant left low-speed clock");
    a_reset_period: assert property (!s_q.core.mode_written
        |-> s_q.core.period == wdtom_pkg::PERIOD_RESET)
        else $error("period not at maximum before first mode write");
    a_halt_holds: assert property (!s_q.core.nonstop && s_q.core.halt && !wr_fire
        |=> $stable(s_q.core.count))
        else $error("counter moved during halt");
    a_stop_freeze: assert property (!s_q.core.nonstop
        && s_q.core.phase != wdtom_pkg::PH_RUN && !wr_fire
        |=> $stable(s_q.core.count))
        else $error("counter moved during stop or stabilisation");
    a_nonstop_runs: assert property (s_q.core.nonstop && s_q.core.stop
        && ls_tick && run && !ovf && !wr_fire
        |=> s_q.core.count == $past(s_q.core.count) + CW'(1))
        else $error("non-stoppable counter held in stop");
    a_ls_wake: assert property (s_q.core.phase == wdtom_pkg::PH_STOP
        && !s_q.core.stop && !s_q.core.wake_wd_x1
        |=> s_q.core.phase == wdtom_pkg::PH_RUN)
        else $error("low-speed watchdog did not resume after stop");
    a_cpu_switch: assert property (s_q.core.phase == wdtom_pkg::PH_STAB
        && !s_q.core.stop && !s_q.core.wake_cpu_x1 && s_q.core.cpu_x1
        |=> s_q.core.phase == wdtom_pkg::PH_RUN)
        else $error("cpu clock switch did not end the wait");

    c_overflow: cover property (ovf);
    c_stab_wake: cover property (s_q.core.phase == wdtom_pkg::PH_STAB
        ##1 s_q.core.phase == wdtom_pkg::PH_RUN);
    c_key_clear: cover property (wr_clear && key_ok);
    c_stopped_rewrite: cover property (wr_mode && s_q.core.mode_written && wd_stopped);

endmodule : wdtom_top

//--- sim/wdtom_top_bench.sv
`timescale 1ns/1ps
module wdtom_top_bench;
    localparam logic [15:0] ix_mode = wdtom_pkg::IDX_MODE;
    localparam logic [15:0] ix_key = wdtom_pkg::IDX_CLEAR_KEY;
    localparam logic [15:0] ix_sys = wdtom_pkg::IDX_SYS_CTRL;
    localparam logic [15:0] ix_sts = wdtom_pkg::IDX_STATUS;
    logic clk_in = 1'b0, rst_n_in = 1'b0, opt = 1'b0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, v, c0, c1, c2, c3;
    logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic awr, wrdy, bvalid, arr, rvalid, req;
    logic [1:0] bresp, rresp, lresp;
    int mismatches = 0, n_checks = 0, cyc = 0;

    wdtom_top i_wdtom_top (.clk_in(clk_in), .rst_n_in(rst_n_in), .option_nonstop_in(opt),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wrdy), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arv),
        .s_axi_arready_out(arr), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .wdt_reset_req_out(req));

    initial forever #12.5 clk_in = ~clk_in;

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    // worst case run is about half of this
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 90000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic rst(input logic o);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        opt <= o;
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
    endtask : rst

    task automatic wr(input logic [15:0] ix, input logic [31:0] d);
        logic a, w;
        a = 1'b0;
        w = 1'b0;
        @(posedge clk_in);
        awaddr <= {14'h0, ix, 2'h0};
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk_in);
            if (awr === 1'b1) a = 1'b1;
            if (wrdy === 1'b1) w = 1'b1;
            if (a) awv <= 1'b0;
            if (w) wv <= 1'b0;
        end while (!(a && w));
        while (bvalid !== 1'b1) @(posedge clk_in);
        bready <= 1'b0;
        lresp = bresp;
    endtask : wr

    task automatic rd(input logic [15:0] ix, output logic [31:0] d);
        @(posedge clk_in);
        araddr <= {14'h0, ix, 2'h0};
        arv <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_in); while (arr !== 1'b1);
        arv <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk_in);
        rready <= 1'b0;
        d = rdata;
        lresp = rresp;
    endtask : rd

    task automatic cnt(output logic [31:0] c);
        rd(ix_sts, v);
        c = {11'h0, v[20:0]};
    endtask : cnt

    task automatic t_reset_vals;
        rst(1'b0);
        rd(ix_mode, v);
        chk("mode_reset", 32'h67, v);
        chk("read_resp", {30'h0, wdtom_pkg::AXI_OKAY}, {30'h0, lresp});
        rd(ix_key, v);
        chk("key_read", 32'h9A, v);
        rd(16'h0004, v);
        chk("unmapped_resp", {30'h0, wdtom_pkg::AXI_SLVERR}, {30'h0, lresp});
        wr(16'h0004, 32'h55);
        chk("unmapped_wr_resp", {30'h0, wdtom_pkg::AXI_SLVERR}, {30'h0, lresp});
        chk("unmapped_wr_quiet", 32'h0, {31'h0, req});
        repeat (1000) @(posedge clk_in);
        cnt(c0);
        chk("ls_count", 32'h1, {31'h0, c0 >= 4 && c0 <= 7});
    endtask : t_reset_vals

    // x1 clock, shortest period: 2^13 ticks of two clocks each
    task automatic t_overflow;
        rst(1'b0);
        wr(ix_mode, 32'h68);
        chk("write_resp", {30'h0, wdtom_pkg::AXI_OKAY}, {30'h0, lresp});
        cnt(c0);
        chk("mode_clears", 32'h1, {31'h0, c0 < 16});
        rd(ix_mode, v);
        chk("mode_x1", 32'h68, v);
        repeat (12000) @(posedge clk_in);
        wr(ix_key, {24'h0, wdtom_pkg::CLEAR_KEY});
        cnt(c1);
        chk("key_clears", 32'h1, {31'h0, c1 < 16});
        repeat (15900) @(posedge clk_in);
        chk("no_early_req", 32'h0, {31'h0, req});
        repeat (1000) @(posedge clk_in);
        chk("overflow_req", 32'h1, {31'h0, req});
    endtask : t_overflow

    // second mode write, bad key, bit-op: reset unless stopped
    task automatic t_faults;
        logic [15:0] ixs [3];
        logic [31:0] ds [3];
        ixs = '{ix_mode, ix_key, ix_key};
        ds = '{32'h60, 32'h55, 32'h1AC};
        for (int s = 0; s < 2; s++) begin
            for (int k = 0; k < 3; k++) begin
                rst(1'b0);
                wr(ix_mode, (s == 1) ? 32'h70 : 32'h60);
                wr(ixs[k], ds[k]);
                repeat (4) @(posedge clk_in);
                chk("fault_req", {31'h0, s == 0}, {31'h0, req});
            end
        end
    endtask : t_faults

    task automatic t_nonstop;
        rst(1'b1);
        wr(ix_mode, 32'h68);
        rd(ix_mode, v);
        chk("clk_sel_kept", 32'h60, v);
        cnt(c0);
        chk("variant", 32'h1, {31'h0, v[22]});
        wr(ix_sys, 32'h2);
        repeat (2000) @(posedge clk_in);
        cnt(c1);
        chk("runs_in_stop", 32'h1, {31'h0, c1 - c0 >= 11 && c1 - c0 <= 13});
    endtask : t_nonstop

    // halt then stop on the low-speed clock
    task automatic t_hold_ls;
        rst(1'b0);
        wr(ix_mode, 32'h60);
        for (int h = 1; h < 3; h++) begin
            wr(ix_sys, h);
            cnt(c0);
            repeat (1000) @(posedge clk_in);
            cnt(c1);
            chk("held", c0, c1);
            wr(ix_sys, 32'h0);
            repeat (1000) @(posedge clk_in);
            cnt(c2);
            chk("resumed", 32'h1, {31'h0, c2 - c1 >= 5 && c2 - c1 <= 7});
        end
    endtask : t_hold_ls

    // stabilisation wait is 2^11 x1 ticks, about 4096 clocks
    task automatic t_stop_x1;
        rst(1'b0);
        wr(ix_mode, 32'h68);
        wr(ix_sys, 32'h4);
        repeat (500) @(posedge clk_in);
        wr(ix_sys, 32'h6);
        cnt(c0);
        repeat (500) @(posedge clk_in);
        cnt(c1);
        chk("x1_stop_held", c0, c1);
        wr(ix_sys, 32'h4);
        repeat (2000) @(posedge clk_in);
        cnt(c2);
        chk("x1_stabilising", c1, c2);
        repeat (3000) @(posedge clk_in);
        cnt(c3);
        chk("x1_resumed", 32'h1, {31'h0, c3 > c2 + 100 && c3 < c2 + 700});
        wr(ix_sys, 32'h0);
        wr(ix_sys, 32'h2);
        repeat (200) @(posedge clk_in);
        wr(ix_sys, 32'h0);
        cnt(c1);
        repeat (1000) @(posedge clk_in);
        cnt(c2);
        chk("ls_cpu_wait", c1, c2);
        wr(ix_sys, 32'h4);
        repeat (200) @(posedge clk_in);
        cnt(c3);
        chk("cpu_switch_wakes", 32'h1, {31'h0, c3 > c2});
    endtask : t_stop_x1

    initial begin
        t_reset_vals();
        t_faults();
        t_nonstop();
        t_hold_ls();
        t_stop_x1();
        t_overflow();
        summarize();
    end
endmodule : wdtom_top_bench
